// [src/otpw_map.svh]
// register offsets, field positions, address bounds and sizing constants for the otp write control
`ifndef OTPW_MAP_SVH
`define OTPW_MAP_SVH
`define OTPW_CTRL_OFF      16'h001D
`define OTPW_LATCH_BIT     2
`define OTPW_HV_BIT        0
`define OTPW_CTRL_RST      8'h00
`define OTPW_ARR_LO        16'h0700
`define OTPW_ARR_HI        16'h1EFF
`define OTPW_VEC_LO        16'h1FF0
`define OTPW_VEC_HI        16'h1FFF
`define OTPW_ROM_LO        16'h1F00
`define OTPW_ROM_HI        16'h1FDF
`define OTPW_MEM_DEPTH     6160
`define OTPW_VEC_BASE_IDX  13'h1800
`define OTPW_PULSE_LANES   4
`define OTPW_ERASED        8'h00
`define OTPW_BLANK         8'h00
`endif

// [src/otpw_pkg.sv]
// types shared by the otp write control files
package otpw_pkg;
    typedef enum logic [2:0] {
        OTPW_IDLE = 3'b001,
        OTPW_READ = 3'b010,
        OTPW_BURN = 3'b100
    } otpw_state_t;
    typedef logic [7:0]  otpw_byte_t;
    typedef logic [12:0] otpw_idx_t;
endpackage

// [src/otpw_mem.sv]
// array storage: byte memory with registered read data and or-only burn writes
`timescale 1ns/1ps
`include "otpw_map.svh"
module otpw_mem (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // read port
    input  wire logic              rd_en,
    input  wire otpw_pkg::otpw_idx_t rd_idx,
    output otpw_pkg::otpw_byte_t   rd_data,
    // burn port
    input  wire logic              wr_en,
    input  wire otpw_pkg::otpw_idx_t wr_idx,
    input  wire otpw_pkg::otpw_byte_t wr_data
);
    // a blank part: every cell starts erased; no process but the burn writes it
    otpw_pkg::otpw_byte_t cells [0:`OTPW_MEM_DEPTH-1] = '{default: `OTPW_ERASED};
    // burning can only set bits, never clear them
    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            cells[wr_idx] <= cells[wr_idx] | wr_data;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_data <= `OTPW_BLANK;
        end else if (rd_en) begin
            rd_data <= cells[rd_idx];
        end
    end
endmodule

// [src/otpw_ctrl.sv]
// otp array write control: control register, write latches, burn sequencing, avalon slave
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`include "otpw_map.svh"
module otpw_ctrl (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // avalon-mm slave, byte address over the 8k map
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [7:0]  avs_writedata,
    output logic      [7:0]  avs_readdata,
    output logic             avs_waitrequest,
    // loader rom data, looked up outside this block
    output logic      [7:0]  rom_addr,
    input  wire logic [7:0]  rom_data,
    // programming supply switch and status
    output logic             hv_connect,
    output logic             array_nvm_write_control_mode,
    output logic      [1:0]  latch_count
);
    otpw_pkg::otpw_state_t state;
    otpw_pkg::otpw_state_t next_state;

    logic                 array_latch_enable;
    logic                 high_voltage_apply;
    logic [13:0]          blk_addr;
    otpw_pkg::otpw_byte_t lane_data  [`OTPW_PULSE_LANES];
    logic                 lane_valid [`OTPW_PULSE_LANES];
    logic [1:0]           burn_lane;
    logic                 rd_is_rom;
    logic                 any_valid;
    logic                 burn_done;

    // reset value held as a constant so its fields can be selected
    localparam logic [7:0] ctrl_rst_val = `OTPW_CTRL_RST;

    // address decode
    logic      hit_ctrl;
    logic      hit_arr;
    logic      hit_vec;
    logic      hit_rom;
    logic      hit_mem;
    otpw_pkg::otpw_idx_t mem_idx;
    always_comb begin
        hit_ctrl = (avs_address == `OTPW_CTRL_OFF);
        hit_arr  = (avs_address >= `OTPW_ARR_LO) && (avs_address <= `OTPW_ARR_HI);
        hit_vec  = (avs_address >= `OTPW_VEC_LO) && (avs_address <= `OTPW_VEC_HI);
        hit_rom  = (avs_address >= `OTPW_ROM_LO) && (avs_address <= `OTPW_ROM_HI);
        hit_mem  = hit_arr || hit_vec;
        if (hit_vec) begin
            mem_idx = `OTPW_VEC_BASE_IDX + {9'h000, avs_address[3:0]};
        end else begin
            mem_idx = 13'(avs_address - `OTPW_ARR_LO);
        end
    end

    // reads of the array take one extra cycle for the registered memory
    logic mem_rd_go;
    assign mem_rd_go = (state == otpw_pkg::OTPW_IDLE) && avs_read && hit_mem
                       && !array_latch_enable;

    always_comb begin
        next_state = state;
        unique case (state)
            otpw_pkg::OTPW_IDLE: begin
                if (mem_rd_go || (avs_read && hit_rom && !array_latch_enable)) begin
                    next_state = otpw_pkg::OTPW_READ;
                end else if (high_voltage_apply && any_valid && !burn_done) begin
                    next_state = otpw_pkg::OTPW_BURN;
                end
            end
            otpw_pkg::OTPW_READ: begin
                next_state = otpw_pkg::OTPW_IDLE;
            end
            otpw_pkg::OTPW_BURN: begin
                // stay until every lane has had its turn, bus stalled meanwhile
                if (burn_lane == 2'b11) begin
                    next_state = otpw_pkg::OTPW_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= otpw_pkg::OTPW_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // register writes take effect whenever waitrequest is low, which is never during burn
    logic ctrl_wr;
    assign ctrl_wr = avs_write && hit_ctrl && !avs_waitrequest;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            array_latch_enable <= ctrl_rst_val[`OTPW_LATCH_BIT];
        end else if (ctrl_wr) begin
            array_latch_enable <= avs_writedata[`OTPW_LATCH_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            high_voltage_apply <= ctrl_rst_val[`OTPW_HV_BIT];
        end else if (ctrl_wr) begin
            // only set when the latch was already on; dropping latch kills supply too
            high_voltage_apply <= avs_writedata[`OTPW_HV_BIT]
                                  && array_latch_enable
                                  && avs_writedata[`OTPW_LATCH_BIT];
        end
    end

    assign hv_connect      = high_voltage_apply;
    assign array_nvm_write_control_mode = array_latch_enable;

    // write latches: up to four bytes of one aligned block
    logic arr_wr;
    logic same_blk;
    assign arr_wr    = avs_write && hit_mem && !avs_waitrequest;
    assign any_valid = lane_valid[0] || lane_valid[1] || lane_valid[2] || lane_valid[3];
    assign same_blk  = !any_valid || (avs_address[15:2] == blk_addr);

    always_ff @(posedge core_clk) begin
        if (sys_rst || !array_latch_enable) begin
            blk_addr <= 14'h0000;
        end else if (arr_wr && same_blk && !high_voltage_apply) begin
            blk_addr <= avs_address[15:2];
        end
    end

    genvar g;
    generate
        for (g = 0; g < `OTPW_PULSE_LANES; g++) begin : g_lane
            always_ff @(posedge core_clk) begin
                if (sys_rst || !array_latch_enable) begin
                    lane_valid[g] <= 1'b0;
                    lane_data[g]  <= `OTPW_BLANK;
                end else if (arr_wr && same_blk && !high_voltage_apply
                             && avs_address[1:0] == 2'(g)) begin
                    lane_valid[g] <= 1'b1;
                    lane_data[g]  <= avs_writedata;
                end
            end
        end
    endgenerate

    always_comb begin
        latch_count = 2'b00;
        for (int i = 0; i < `OTPW_PULSE_LANES; i++) begin
            if (lane_valid[i]) begin
                latch_count = 2'(i);
            end
        end
    end

    // burn: once supply is on, latched lanes are written one per cycle
    logic mem_wr;
    otpw_pkg::otpw_idx_t burn_idx;
    assign mem_wr = (state == otpw_pkg::OTPW_BURN) && lane_valid[burn_lane]
                    && high_voltage_apply && !burn_done;
    always_comb begin
        if ({blk_addr, 2'b00} >= `OTPW_VEC_LO) begin
            burn_idx = `OTPW_VEC_BASE_IDX + {9'h000, blk_addr[1:0], burn_lane};
        end else begin
            burn_idx = 13'({blk_addr, burn_lane} - `OTPW_ARR_LO);
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || !array_latch_enable || !high_voltage_apply) begin
            burn_lane <= 2'b00;
            burn_done <= 1'b0;
        end else if (state == otpw_pkg::OTPW_BURN) begin
            burn_lane <= burn_lane + 2'b01;
            if (burn_lane == 2'b11) begin
                burn_done <= 1'b1;
            end
        end
    end

    otpw_pkg::otpw_byte_t mem_q;
    otpw_mem u_mem (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .rd_en    (mem_rd_go),
        .rd_idx   (mem_idx),
        .rd_data  (mem_q),
        .wr_en    (mem_wr),
        .wr_idx   (burn_idx),
        .wr_data  (lane_data[burn_lane])
    );

    // rom index: captured with the read so the lookup settles over the wait cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rom_addr  <= 8'h00;
            rd_is_rom <= 1'b0;
        end else if (state == otpw_pkg::OTPW_IDLE && avs_read) begin
            rom_addr  <= avs_address[7:0];
            rd_is_rom <= hit_rom;
        end
    end

    // bus answer: control, unmapped and latched reads answer at once, memory reads one cycle later
    logic slow_rd;
    assign slow_rd = avs_read && (hit_mem || hit_rom) && !array_latch_enable;
    assign avs_waitrequest = (state == otpw_pkg::OTPW_BURN)
                             || (state == otpw_pkg::OTPW_IDLE && slow_rd);

    always_comb begin
        avs_readdata = 8'h00;
        if (state == otpw_pkg::OTPW_READ) begin
            avs_readdata = rd_is_rom ? rom_data : mem_q;
        end else if (hit_ctrl) begin
            avs_readdata[`OTPW_LATCH_BIT] = array_latch_enable;
            avs_readdata[`OTPW_HV_BIT]    = high_voltage_apply;
        end
        // latch set: array and loader rom read as zero, never contents
    end
endmodule

// [tb/otpw_ctrl_chk.sv]
// port assertions for the otp write control
`timescale 1ns/1ps
module otpw_ctrl_chk (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // register bus
    input wire logic [15:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [7:0]  avs_writedata,
    input wire logic [7:0]  avs_readdata,
    input wire logic        avs_waitrequest,
    // rom, supply and status
    input wire logic [7:0]  rom_addr,
    input wire logic [7:0]  rom_data,
    input wire logic        hv_connect,
    input wire logic        array_nvm_write_control_mode,
    input wire logic [1:0]  latch_count
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_ctl_wr;
        avs_write && !avs_waitrequest && avs_address == 16'h001D;
    endsequence
    sequence s_rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    a_hv_needs_latch: assert property (hv_connect |-> array_nvm_write_control_mode)
        else $error("supply connected without latch");
    a_latch_sets: assert property (s_ctl_wr ##0 avs_writedata[2] |=> array_nvm_write_control_mode)
        else $error("latch bit not taken");
    a_latch_clr_hv: assert property (s_ctl_wr ##0 !avs_writedata[2]
        |=> !array_nvm_write_control_mode && !hv_connect) else $error("latch clear left a bit set");
    a_both_once: assert property (s_ctl_wr ##0 !array_nvm_write_control_mode |=> !hv_connect)
        else $error("supply set without prior latch");
    a_hv_accept: assert property (s_ctl_wr ##0 avs_writedata[2:0] == 3'h5
        && array_nvm_write_control_mode |=> hv_connect) else $error("supply write refused");
    a_ctl_read: assert property (s_rd_done ##0 avs_address == 16'h001D
        |-> avs_readdata == {5'h00, array_nvm_write_control_mode, 1'h0, hv_connect})
        else $error("control readback wrong");
    a_arr_hidden: assert property (s_rd_done ##0 array_nvm_write_control_mode
        && avs_address inside {[16'h0700:16'h1EFF]} |-> avs_readdata == 8'h00)
        else $error("array visible while latched");
    a_rom_block: assert property (s_rd_done ##0 array_nvm_write_control_mode
        && avs_address inside {[16'h1F00:16'h1FDF]} |-> avs_readdata == 8'h00)
        else $error("rom visible while latched");
    a_rom_pass: assert property (s_rd_done ##0 !array_nvm_write_control_mode
        && avs_address inside {[16'h1F00:16'h1FDF]}
        |-> avs_readdata == rom_data && rom_addr == avs_address[7:0])
        else $error("rom read wrong");
endmodule

// [tb/otpw_tb.sv]
// testbench for the otp write control
`timescale 1ns/1ps
module tb;
    logic        core_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
    logic [15:0] avs_address = 16'h0000;
    logic [7:0]  avs_writedata = 8'h00, avs_readdata, rom_addr, rom_data;
    logic        avs_waitrequest, hv_connect, array_nvm_write_control_mode;
    logic [1:0]  latch_count;
    int          num_errors = 0, compares = 0;
    // rom answers combinationally from its address
    assign rom_data = rom_addr ^ 8'hA5;
    always #25 core_clk = ~core_clk;
    otpw_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rom_addr(rom_addr),
        .rom_data(rom_data), .hv_connect(hv_connect), .array_nvm_write_control_mode(array_nvm_write_control_mode),
        .latch_count(latch_count));
    task automatic print_verdict;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    // one idle edge after each access keeps strobes from toggling twice in a step
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(n, e, q);
    endtask
    // programming supply is taken as present on its pin throughout
    task automatic nvm_write_control(input logic [15:0] a, input logic [7:0] d);
        wr(16'h001D, 8'h04);
        wr(a, d);
        wr(16'h001D, 8'h05);
        repeat (8) @(posedge core_clk);
        wr(16'h001D, 8'h00);
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rd(16'h001D, 8'h00, "ctrl reset");
        rd(16'h0700, 8'h00, "blank low");
        rd(16'h1EFF, 8'h00, "blank high");
        rd(16'h1F00, 8'hA5, "rom first");
        rd(16'h1FDF, 8'h7A, "rom last");
        rd(16'h0200, 8'h00, "unmapped");
        wr(16'h0700, 8'hFF);
        rd(16'h0700, 8'h00, "unlatched write");
        wr(16'h001D, 8'h01);
        rd(16'h001D, 8'h00, "supply alone");
        wr(16'h001D, 8'hFF);
        rd(16'h001D, 8'h04, "both bits");
        chk("nvm_write_control mode", 8'h01, {7'h00, array_nvm_write_control_mode});
        for (int i = 0; i < 4; i++) wr(16'h0704 + 16'(i), 8'h5A + 8'(i));
        wr(16'h0708, 8'hFF);
        chk("lanes", 8'h03, {6'h00, latch_count});
        rd(16'h0704, 8'h00, "latched read");
        rd(16'h1F00, 8'h00, "rom blocked");
        wr(16'h001D, 8'h05);
        repeat (8) @(posedge core_clk);
        rd(16'h001D, 8'h05, "supply on");
        chk("supply pin", 8'h01, {7'h00, hv_connect});
        wr(16'h001D, 8'h00);
        rd(16'h001D, 8'h00, "latch clear");
        chk("supply off", 8'h00, {7'h00, hv_connect});
        for (int i = 0; i < 4; i++) rd(16'h0704 + 16'(i), 8'h5A + 8'(i), "burned");
        rd(16'h0708, 8'h00, "other block");
        nvm_write_control(16'h0704, 8'h81);
        rd(16'h0704, 8'hDB, "or only");
        nvm_write_control(16'h1FF0, 8'h12);
        rd(16'h1FF0, 8'h12, "vector");
        print_verdict();
    end
    initial begin
        repeat (2000) @(posedge core_clk);
        num_errors++;
        print_verdict();
    end
endmodule
bind otpw_ctrl otpw_ctrl_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rom_addr(rom_addr), .rom_data(rom_data),
    .hv_connect(hv_connect), .array_nvm_write_control_mode(array_nvm_write_control_mode), .latch_count(latch_count));
